// [hdl/flash_addr_map.v]
// Byte address to sector and block number decode
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_consts.vh"

module flash_addr_map (
    input wire [`ADDR_W-1:0] addr,
    output wire [`SECTOR_W-1:0] sector,
    output wire [`BLOCK32_W-1:0] block32,
    output wire [`BLOCK64_W-1:0] block64
);

// Sector n covers n*4096 .. n*4096+4095; blocks are 8 or 16 adjacent sectors
assign sector = addr[`ADDR_W-1:`SECTOR_SHIFT];
assign block32 = addr[`ADDR_W-1:`BLOCK32_SHIFT];
assign block64 = addr[`ADDR_W-1:`BLOCK64_SHIFT];

endmodule

`default_nettype wire

// [hdl/flash_status_consts.vh]
// Constants for the serial flash status register, opcodes and array map
`ifndef FLASH_STATUS_CONSTS_VH
`define FLASH_STATUS_CONSTS_VH

// Status register bit positions
`define STAT_BUSY 0
`define STAT_WEL 1
`define STAT_BP_LO 2
`define STAT_BP_HI 5
`define STAT_QE 6
`define STAT_WD 7
`define STAT_RESET 8'h00
`define BP_CLEAR 4'h0

// Command opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK32_ERASE 8'h52
`define OP_BLOCK64_ERASE 8'hd8
`define OP_CHIP_ERASE 8'hc7
`define OP_CHIP_ERASE_ALT 8'h60

// Operation kinds reported to the array
`define KIND_STATUS 3'h0
`define KIND_PROGRAM 3'h1
`define KIND_SECTOR 3'h2
`define KIND_BLOCK32 3'h3
`define KIND_BLOCK64 3'h4
`define KIND_CHIP 3'h5

// Array map: 4 KB sectors, 32 KB and 64 KB blocks, 25-bit byte address
`define ADDR_W 25
`define TOP_ADDR 25'h1ffffff
`define SECTOR_SHIFT 12
`define BLOCK32_SHIFT 15
`define BLOCK64_SHIFT 16
`define SECTOR_W 13
`define BLOCK32_W 10
`define BLOCK64_W 9
`define ADDR_BYTES 4

// Internal write cycle lengths in clk_sys cycles
`define BUSY_CNT_W 24
`define STATUS_WRITE_CYCLES 24'h000040
`define PROGRAM_CYCLES 24'h000100
`define SECTOR_ERASE_CYCLES 24'h000400
`define BLOCK_ERASE_CYCLES 24'h000800
`define CHIP_ERASE_CYCLES 24'h001000

`endif

// [hdl/flash_status_reg.v]
// Serial flash status register with its command front end over the serial bus
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_consts.vh"

module flash_status_reg #(
    parameter [`BUSY_CNT_W-1:0] STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES,
    parameter [`BUSY_CNT_W-1:0] PROGRAM_CYCLES = `PROGRAM_CYCLES,
    parameter [`BUSY_CNT_W-1:0] SECTOR_ERASE_CYCLES = `SECTOR_ERASE_CYCLES,
    parameter [`BUSY_CNT_W-1:0] BLOCK_ERASE_CYCLES = `BLOCK_ERASE_CYCLES,
    parameter [`BUSY_CNT_W-1:0] CHIP_ERASE_CYCLES = `CHIP_ERASE_CYCLES
) (
    input wire clk_sys,
    input wire rstn,
    input wire ce_n,
    input wire sck,
    input wire si,
    input wire wp_n,
    output reg so,
    output reg so_oe,
    output reg [7:0] flash_status,
    output reg op_start,
    output reg [2:0] op_kind,
    output reg [`ADDR_W-1:0] op_addr,
    output reg [`SECTOR_W-1:0] op_sector,
    output reg [`BLOCK32_W-1:0] op_block32,
    output reg [`BLOCK64_W-1:0] op_block64,
    output reg prog_valid,
    output reg [7:0] prog_data
);

localparam S_CMD = 5'b00001;
localparam S_ADDR = 5'b00010;
localparam S_DATA = 5'b00100;
localparam S_READ = 5'b01000;
localparam S_HOLD = 5'b10000;
localparam [2:0] LAST_ADDR = `ADDR_BYTES - 1;

////////////////////////////////////////////////////////////////////////////////
// Status bits
reg status_write_disable;
reg quad_enable;
reg [3:0] protect_bits;
reg write_enable_latch;
reg busy_flag;
reg [`BUSY_CNT_W-1:0] busy_cnt;
wire [7:0] status_now = {status_write_disable, quad_enable, protect_bits,
                         write_enable_latch, busy_flag};

////////////////////////////////////////////////////////////////////////////////
// Serial front end
reg sck_q;
reg ce_q;
reg [4:0] state;
reg [2:0] bit_cnt;
reg [2:0] out_cnt;
reg [2:0] addr_cnt;
reg [7:0] shift_in;
reg [7:0] cmd;
reg [31:0] addr_sh;
reg [7:0] data_byte;
reg [7:0] out_sh;
reg frame_ok;
wire rise;
wire fall;
wire frame_end;
wire byte_done;
wire [7:0] next_byte;
wire [`SECTOR_W-1:0] map_sector;
wire [`BLOCK32_W-1:0] map_block32;
wire [`BLOCK64_W-1:0] map_block64;

// Mode 0 and 3: input taken on rising clock, output moved on falling clock
assign rise = sck & ~sck_q & ~ce_n;
assign fall = ~sck & sck_q & ~ce_n;
assign frame_end = ce_n & ~ce_q;
assign next_byte = {shift_in[6:0], si};
assign byte_done = rise && (bit_cnt == 3'h7);

flash_addr_map u_map (
    .addr(addr_sh[`ADDR_W-1:0]),
    .sector(map_sector),
    .block32(map_block32),
    .block64(map_block64)
);

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        sck_q <= 1'b0;
        ce_q <= 1'b1;
    end else begin
        sck_q <= sck;
        ce_q <= ce_n;
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        state <= S_CMD;
        bit_cnt <= 3'h0;
        out_cnt <= 3'h0;
        addr_cnt <= 3'h0;
        shift_in <= 8'h00;
        cmd <= 8'h00;
        addr_sh <= 32'h00000000;
        data_byte <= 8'h00;
        out_sh <= 8'h00;
        frame_ok <= 1'b0;
        so <= 1'b0;
        so_oe <= 1'b0;
        prog_valid <= 1'b0;
        prog_data <= 8'h00;
    end else begin
        prog_valid <= 1'b0;
        if (ce_n) begin
            // Deselect ends the frame; the execute stage reads frame_ok first
            state <= S_CMD;
            bit_cnt <= 3'h0;
            out_cnt <= 3'h0;
            addr_cnt <= 3'h0;
            frame_ok <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            if (rise) begin
                shift_in <= next_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (byte_done) begin
                case (state)
                    S_CMD: begin
                        cmd <= next_byte;
                        if (busy_flag && next_byte != `OP_STATUS_READ) begin
                            state <= S_HOLD;
                        end else begin
                            case (next_byte)
                                `OP_STATUS_READ: begin
                                    state <= S_READ;
                                    out_sh <= status_now;
                                    out_cnt <= 3'h0;
                                    so_oe <= 1'b1;
                                end
                                `OP_STATUS_WRITE: state <= S_DATA;
                                `OP_PAGE_PROGRAM, `OP_SECTOR_ERASE,
                                `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE: begin
                                    state <= S_ADDR;
                                end
                                `OP_WRITE_ENABLE, `OP_WRITE_DISABLE,
                                `OP_CHIP_ERASE, `OP_CHIP_ERASE_ALT: begin
                                    state <= S_HOLD;
                                    frame_ok <= 1'b1;
                                end
                                default: state <= S_HOLD;
                            endcase
                        end
                    end
                    S_ADDR: begin
                        addr_sh <= {addr_sh[23:0], next_byte};
                        addr_cnt <= addr_cnt + 3'h1;
                        if (addr_cnt == LAST_ADDR) begin
                            frame_ok <= 1'b1;
                            state <= (cmd == `OP_PAGE_PROGRAM) ? S_DATA : S_HOLD;
                        end
                    end
                    S_DATA: begin
                        data_byte <= next_byte;
                        if (cmd == `OP_STATUS_WRITE) begin
                            frame_ok <= 1'b1;
                            state <= S_HOLD;
                        end else if (write_enable_latch) begin
                            prog_valid <= 1'b1;
                            prog_data <= next_byte;
                        end
                    end
                    default: state <= state;
                endcase
            end
            if (fall && state == S_READ) begin
                so <= out_sh[7];
                out_cnt <= out_cnt + 3'h1;
                // Reload after every byte so the register repeats until deselect
                if (out_cnt == 3'h7) begin
                    out_sh <= status_now;
                end else begin
                    out_sh <= {out_sh[6:0], 1'b0};
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Execute stage and internal write cycle
// Commands other than status read act only when select rises on a byte boundary
wire exec = frame_end && frame_ok && (bit_cnt == 3'h0) && !busy_flag;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        status_write_disable <= 1'b0;
        quad_enable <= 1'b0;
        protect_bits <= `BP_CLEAR;
        write_enable_latch <= 1'b0;
        busy_flag <= 1'b0;
        busy_cnt <= {`BUSY_CNT_W{1'b0}};
        op_start <= 1'b0;
        op_kind <= `KIND_STATUS;
        op_addr <= {`ADDR_W{1'b0}};
        op_sector <= {`SECTOR_W{1'b0}};
        op_block32 <= {`BLOCK32_W{1'b0}};
        op_block64 <= {`BLOCK64_W{1'b0}};
        flash_status <= `STAT_RESET;
    end else begin
        op_start <= 1'b0;
        flash_status <= status_now;
        if (busy_flag) begin
            if (busy_cnt == {`BUSY_CNT_W{1'b0}}) begin
                busy_flag <= 1'b0;
                write_enable_latch <= 1'b0;
            end else begin
                busy_cnt <= busy_cnt - {{(`BUSY_CNT_W-1){1'b0}}, 1'b1};
            end
        end else if (exec) begin
            op_addr <= addr_sh[`ADDR_W-1:0];
            op_sector <= map_sector;
            op_block32 <= map_block32;
            op_block64 <= map_block64;
            case (cmd)
                `OP_WRITE_ENABLE: write_enable_latch <= 1'b1;
                `OP_WRITE_DISABLE: write_enable_latch <= 1'b0;
                `OP_STATUS_WRITE: begin
                    // Latch and busy bits are not taken from the written byte
                    if (write_enable_latch && (!status_write_disable || wp_n)) begin
                        status_write_disable <= data_byte[`STAT_WD];
                        quad_enable <= data_byte[`STAT_QE];
                        protect_bits <= data_byte[`STAT_BP_HI:`STAT_BP_LO];
                        busy_flag <= 1'b1;
                        busy_cnt <= STATUS_WRITE_CYCLES;
                        op_start <= 1'b1;
                        op_kind <= `KIND_STATUS;
                    end
                end
                `OP_PAGE_PROGRAM: begin
                    if (write_enable_latch) begin
                        busy_flag <= 1'b1;
                        busy_cnt <= PROGRAM_CYCLES;
                        op_start <= 1'b1;
                        op_kind <= `KIND_PROGRAM;
                    end
                end
                `OP_SECTOR_ERASE: begin
                    if (write_enable_latch) begin
                        busy_flag <= 1'b1;
                        busy_cnt <= SECTOR_ERASE_CYCLES;
                        op_start <= 1'b1;
                        op_kind <= `KIND_SECTOR;
                    end
                end
                `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE: begin
                    if (write_enable_latch) begin
                        busy_flag <= 1'b1;
                        busy_cnt <= BLOCK_ERASE_CYCLES;
                        op_start <= 1'b1;
                        op_kind <= (cmd == `OP_BLOCK32_ERASE) ? `KIND_BLOCK32 : `KIND_BLOCK64;
                    end
                end
                `OP_CHIP_ERASE, `OP_CHIP_ERASE_ALT: begin
                    if (write_enable_latch && protect_bits == `BP_CLEAR) begin
                        busy_flag <= 1'b1;
                        busy_cnt <= CHIP_ERASE_CYCLES;
                        op_start <= 1'b1;
                        op_kind <= `KIND_CHIP;
                    end
                end
                default: busy_flag <= 1'b0;
            endcase
        end
    end
end

endmodule

`default_nettype wire

// [sim/flash_status_sva.sv]
// Assertions on the ports of the flash status register
`timescale 1ns/1ps
`default_nettype none
module flash_status_sva #(
    parameter [23:0] STATUS_WRITE_CYCLES = 24'h000040
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce_n,
    input wire logic so_oe,
    input wire logic [7:0] flash_status,
    input wire logic op_start,
    input wire logic [2:0] op_kind,
    input wire logic [24:0] op_addr,
    input wire logic [12:0] op_sector,
    input wire logic [9:0] op_block32,
    input wire logic [8:0] op_block64,
    input wire logic prog_valid
);
    logic [31:0] busy_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Counts how long the busy flag has been shown
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= flash_status[0] ? busy_cnt + 32'h1 : 32'h0;
        end
    end
    busy_follows_a: assert property (op_start |=> flash_status[0])
        else $error("busy not raised");
    busy_cause_a: assert property ($rose(flash_status[0]) |-> $past(op_start))
        else $error("busy without start");
    busy_refuse_a: assert property (flash_status[0] |-> !op_start)
        else $error("start while busy");
    latch_needed_a: assert property (op_start |-> flash_status[1])
        else $error("start without latch");
    latch_clear_a: assert property ($fell(flash_status[0]) |-> !flash_status[1])
        else $error("latch kept after write");
    chip_guard_a: assert property (op_start && op_kind == 3'h5 |-> !flash_status[5:2])
        else $error("chip erase while protected");
    map_decode_a: assert property (op_start && op_kind inside {[3'h1:3'h4]} |->
        op_sector == op_addr[24:12] && op_block32 == op_addr[24:15]
        && op_block64 == op_addr[24:16])
        else $error("bad sector map");
    busy_len_a: assert property ($fell(flash_status[0]) && op_kind == 3'h0 |->
        busy_cnt == STATUS_WRITE_CYCLES + 1)
        else $error("busy length wrong");
    oe_release_a: assert property (ce_n [*3] |-> !so_oe)
        else $error("output driven while deselected");
    cover property (op_start && op_kind == 3'h0);
    cover property (op_start && op_kind == 3'h5);
    cover property (prog_valid);
endmodule
bind flash_status_reg flash_status_sva #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_sva (
    .clk_sys(clk_sys), .rstn(rstn), .ce_n(ce_n), .so_oe(so_oe), .flash_status(flash_status),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_sector(op_sector),
    .op_block32(op_block32), .op_block64(op_block64), .prog_valid(prog_valid));
`default_nettype wire

// [sim/spi_host.sv]
// Serial bus host model that sends whole command frames
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    input wire logic clk_sys,
    input wire logic so,
    output logic ce_n,
    output logic sck,
    output logic si
);
    localparam int HALF = 4;
    initial begin
        ce_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Mode 0, MSB first; reply bits are read just before each rise
    task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] r;
        rx = {};
        tick(1);
        ce_n = 1'b0;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                si = tx[k][i];
                tick(HALF);
                r[i] = so;
                sck = 1'b1;
                tick(HALF);
                sck = 1'b0;
            end
            rx.push_back(r);
        end
        tick(HALF);
        ce_n = 1'b1;
        si = ~si;
        tick(HALF);
    endtask
endmodule
`default_nettype wire

// [sim/test_flash_status_reg_and_map.sv]
// Self-checking bench for the flash status register and array map
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_consts.vh"
module test_flash_status_reg_and_map;
    logic clk_sys, rstn, wp_n, so, so_oe, op_start, prog_valid;
    logic [7:0] flash_status, prog_data, rx[$], tx[$], prog_q[$];
    logic [2:0] op_kind;
    logic [24:0] op_addr;
    logic [12:0] op_sector;
    logic [9:0] op_block32;
    logic [8:0] op_block64;
    logic [27:0] op_q[$];
    wire ce_n, sck, si;
    int fail_count = 0;
    int n_compared = 0;
    flash_status_reg #(.STATUS_WRITE_CYCLES(24'h000190)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .ce_n(ce_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .flash_status(flash_status), .op_start(op_start),
        .op_kind(op_kind), .op_addr(op_addr), .op_sector(op_sector),
        .op_block32(op_block32), .op_block64(op_block64), .prog_valid(prog_valid),
        .prog_data(prog_data));
    // A released output reads as the inverse, so a late enable shows up
    spi_host u_host (.clk_sys(clk_sys), .so(so_oe ? so : ~so), .ce_n(ce_n), .sck(sck), .si(si));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic bad(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        fail_count++;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) bad($sformatf("status %h, wanted %h", got, exp));
    endtask
    task automatic cmp_op(input logic [27:0] e);
        logic [24:0] a;
        a = e[24:0];
        n_compared++;
        if (op_kind !== e[27:25]) bad("operation kind");
        else if (e[27:25] != `KIND_STATUS && e[27:25] != `KIND_CHIP && {op_addr, op_sector,
            op_block32, op_block64} !== {a, a[24:12], a[24:15], a[24:16]}) bad("address map");
    endtask
    task automatic cmp_prog(input logic [7:0] e);
        n_compared++;
        if (prog_data !== e) bad("program byte");
    endtask
    // Results are matched against the oldest expectation as they appear
    always @(negedge clk_sys) begin
        if (op_start === 1'b1) begin
            if (op_q.size() == 0) bad("operation not expected");
            else cmp_op(op_q.pop_front());
        end
        if (prog_valid === 1'b1) begin
            if (prog_q.size() == 0) bad("program byte not expected");
            else cmp_prog(prog_q.pop_front());
        end
    end
    task automatic cmd(input logic [7:0] b[$]);
        u_host.frame(b, rx);
    endtask
    task automatic rd_status(input int n, input logic [7:0] exp);
        tx = {`OP_STATUS_READ};
        repeat (n) tx.push_back(8'h00);
        u_host.frame(tx, rx);
        for (int i = 1; i <= n; i++) cmp8(rx[i], exp);
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 5000 && flash_status[0] !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 5000) begin
            bad("busy never cleared");
            results();
        end
    endtask
    task automatic addr_op(input logic [7:0] op, input logic [2:0] kind, input logic [31:0] a);
        cmd({`OP_WRITE_ENABLE});
        op_q.push_back({kind, a[24:0]});
        cmd({op, a[31:24], a[23:16], a[15:8], a[7:0]});
        wait_idle();
    endtask
    initial begin
        logic [31:0] a, d;
        logic [7:0] eops[3], cops[2];
        eops = '{`OP_SECTOR_ERASE, `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE};
        cops = '{`OP_CHIP_ERASE, `OP_CHIP_ERASE_ALT};
        rstn = 1'b0;
        wp_n = 1'b1;
        void'($urandom(96));
        repeat (12) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        u_host.tick(2);
        cmp8(flash_status, `STAT_RESET);
        rd_status(3, 8'h00);
        cmd({`OP_WRITE_ENABLE});
        cmp8(flash_status, 8'h02);
        cmd({`OP_WRITE_DISABLE});
        cmp8(flash_status, 8'h00);
        cmd({`OP_WRITE_ENABLE});
        op_q.push_back({`KIND_STATUS, 25'h0});
        cmd({`OP_STATUS_WRITE, 8'h5d});
        cmd({`OP_WRITE_DISABLE});
        rd_status(2, 8'h5f);
        wait_idle();
        cmp8(flash_status, 8'h5c);
        cmd({`OP_WRITE_ENABLE});
        cmd({`OP_CHIP_ERASE});
        cmp8(flash_status, 8'h5e);
        op_q.push_back({`KIND_STATUS, 25'h0});
        cmd({`OP_STATUS_WRITE, 8'h80});
        wait_idle();
        cmp8(flash_status, 8'h80);
        wp_n = 1'b0;
        cmd({`OP_WRITE_ENABLE});
        cmd({`OP_STATUS_WRITE, 8'h00});
        cmp8(flash_status, 8'h82);
        wp_n = 1'b1;
        op_q.push_back({`KIND_STATUS, 25'h0});
        cmd({`OP_STATUS_WRITE, 8'h00});
        wait_idle();
        cmp8(flash_status, 8'h00);
        foreach (eops[k]) begin
            addr_op(eops[k], `KIND_SECTOR + k[2:0], $urandom);
            addr_op(eops[k], `KIND_SECTOR + k[2:0], 32'h01ffffff);
        end
        foreach (cops[k]) begin
            cmd({`OP_WRITE_ENABLE});
            op_q.push_back({`KIND_CHIP, 25'h0});
            cmd({cops[k]});
            wait_idle();
        end
        a = $urandom;
        d = $urandom;
        cmd({`OP_WRITE_ENABLE});
        op_q.push_back({`KIND_PROGRAM, a[24:0]});
        prog_q.push_back(d[7:0]);
        prog_q.push_back(d[15:8]);
        cmd({`OP_PAGE_PROGRAM, a[31:24], a[23:16], a[15:8], a[7:0], d[7:0], d[15:8]});
        wait_idle();
        cmd({`OP_PAGE_PROGRAM, a[31:24], a[23:16], a[15:8], a[7:0], d[23:16]});
        cmp8(flash_status, 8'h00);
        n_compared++;
        if (op_q.size() != 0 || prog_q.size() != 0) bad("expected result never came");
        results();
    end
endmodule
`default_nettype wire
